//--- hw/omcs_pkg.sv
// Constants and types for the optical module control and status block
// Overview of operation
// - Disable pin rising kills light within 10 us
// - Disable pin falling restores light within 2 ms
// - Initialisation ends within 300 ms, fault cleared
// - Fault output asserts within 100 us
// - Loss output asserts within 100 us
// - Loss output clears within 100 us
// - Soft disable set kills light within 100 ms
// - Soft disable clear restores light within 100 ms
// - Fault status bit sets within 100 ms
// - Loss status bit follows within 100 ms
// - Data ready bit within 1000 ms of power-on
// - Serial accesses accepted within 300 ms
// - Write cycle 40 ms short, 80 ms long
// - Serial clock at most 400 kHz
package omcs_pkg;
  localparam int CLK_KHZ = 100000;
  localparam int T_ON_MS = 2;
  localparam int T_INIT_MS = 300;
  localparam int T_SERIAL_MS = 300;
  localparam int T_DATA_MS = 1000;
  localparam int T_WR_SHORT_MS = 40;
  localparam int T_WR_LONG_MS = 80;
  localparam int T_ON_CYC = T_ON_MS * CLK_KHZ;
  localparam int T_INIT_CYC = T_INIT_MS * CLK_KHZ;
  localparam int T_SERIAL_CYC = T_SERIAL_MS * CLK_KHZ;
  localparam int T_DATA_CYC = T_DATA_MS * CLK_KHZ;
  localparam int T_WR_SHORT_CYC = T_WR_SHORT_MS * CLK_KHZ;
  localparam int T_WR_LONG_CYC = T_WR_LONG_MS * CLK_KHZ;
  localparam logic [3:0] WR_SHORT_MAX = 4'h4;
  localparam logic [3:0] WR_COUNT_MAX = 4'hF;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [6:0] IDENTITY_ADDRESS = 7'h50;
  localparam logic [6:0] DIAGNOSTIC_ADDRESS = 7'h51;
  localparam logic [7:0] SOFT_CONTROL_AND_STATUS = 8'h6E;
  localparam logic [7:0] READ_FILL = 8'h00;
  localparam int BIT_PIN_DISABLE = 7;
  localparam int BIT_SOFT_DISABLE = 6;
  localparam int BIT_TX_FAULT = 2;
  localparam int BIT_RX_LOS = 1;
  localparam int BIT_DATA_READY = 0;
  localparam logic SOFT_DISABLE_RESET = 1'b0;

  typedef enum logic [2:0] {
    OMCS_IDLE = 3'h0,
    OMCS_ADDR = 3'h1,
    OMCS_ADDR_ACK = 3'h2,
    OMCS_WDATA = 3'h3,
    OMCS_WACK = 3'h4,
    OMCS_RDATA = 3'h5,
    OMCS_RACK = 3'h6
  } omcs_twi_state_t;
endpackage

//--- hw/omcs_twi_slave.sv
// Two-wire management slave, oversampled on the system clock
`timescale 1ns/1ps
module omcs_twi_slave (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_ready,
  input wire logic [7:0] i_rd_data,
  output logic o_drive_low,
  output logic o_dev_diag,
  output logic [7:0] o_ptr,
  output logic o_wr_en,
  output logic [7:0] o_wr_addr,
  output logic [7:0] o_wr_data,
  output logic o_stop_write,
  output logic [3:0] o_wr_bytes
);
  logic [2:0] scl_q;
  logic [2:0] sda_q;
  logic rise, fall, start, stop, sda;
  omcs_pkg::omcs_twi_state_t state, next_state;
  logic [3:0] cnt, next_cnt, next_wr_bytes;
  logic [7:0] sh, next_sh, next_ptr, next_wr_addr, next_wr_data;
  logic is_rd, next_is_rd, next_dev_diag, first, next_first;
  logic ack_ok, next_ack_ok, wrote, next_wrote;
  logic next_drive_low, next_wr_en, next_stop_write;

  // Bit 0 only feeds bit 1: edges are judged on the settled taps
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else begin
      scl_q <= {scl_q[1:0], i_scl};
      sda_q <= {sda_q[1:0], i_sda};
    end
  end

  // Any rate up to the bus limit is sampled many times per bit
  assign sda = sda_q[1];
  assign rise = scl_q[1] & ~scl_q[2];
  assign fall = ~scl_q[1] & scl_q[2];
  assign start = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
  assign stop = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_sh = sh;
    next_ptr = o_ptr;
    next_is_rd = is_rd;
    next_dev_diag = o_dev_diag;
    next_first = first;
    next_ack_ok = ack_ok;
    next_wrote = wrote;
    next_drive_low = o_drive_low;
    next_wr_en = 1'b0;
    next_wr_addr = o_wr_addr;
    next_wr_data = o_wr_data;
    next_stop_write = 1'b0;
    next_wr_bytes = o_wr_bytes;
    if (stop) begin
      next_state = omcs_pkg::OMCS_IDLE;
      next_drive_low = 1'b0;
      next_stop_write = wrote;
      next_wrote = 1'b0;
    end else if (start) begin
      next_state = omcs_pkg::OMCS_ADDR;
      next_cnt = 4'h0;
      next_drive_low = 1'b0;
    end else begin
      unique case (state)
        omcs_pkg::OMCS_IDLE: begin
        end
        omcs_pkg::OMCS_ADDR, omcs_pkg::OMCS_WDATA: begin
          if (rise) begin
            next_sh = {sh[6:0], sda};
            next_cnt = cnt + 4'h1;
          end else if (fall && cnt == omcs_pkg::BITS_PER_BYTE) begin
            if (state == omcs_pkg::OMCS_ADDR) begin
              next_state = omcs_pkg::OMCS_IDLE;
              if (i_ready && (sh[7:1] == omcs_pkg::IDENTITY_ADDRESS ||
                  sh[7:1] == omcs_pkg::DIAGNOSTIC_ADDRESS)) begin
                next_state = omcs_pkg::OMCS_ADDR_ACK;
                next_drive_low = 1'b1;
                next_is_rd = sh[0];
                next_dev_diag = sh[7:1] == omcs_pkg::DIAGNOSTIC_ADDRESS;
                next_wr_bytes = 4'h0;
              end
            end else begin
              next_state = omcs_pkg::OMCS_WACK;
              next_drive_low = 1'b1;
              next_first = 1'b0;
              if (first) begin
                next_ptr = sh;
              end else begin
                next_wr_en = 1'b1;
                next_wr_addr = o_ptr;
                next_wr_data = sh;
                next_ptr = o_ptr + 8'h01;
                next_wrote = 1'b1;
                if (o_wr_bytes != omcs_pkg::WR_COUNT_MAX) begin
                  next_wr_bytes = o_wr_bytes + 4'h1;
                end
              end
            end
          end
        end
        omcs_pkg::OMCS_ADDR_ACK: begin
          if (fall) begin
            next_cnt = 4'h0;
            if (is_rd) begin
              next_state = omcs_pkg::OMCS_RDATA;
              next_sh = i_rd_data;
              next_drive_low = ~i_rd_data[7];
            end else begin
              next_state = omcs_pkg::OMCS_WDATA;
              next_drive_low = 1'b0;
              next_first = 1'b1;
            end
          end
        end
        omcs_pkg::OMCS_WACK: begin
          if (fall) begin
            next_state = omcs_pkg::OMCS_WDATA;
            next_drive_low = 1'b0;
            next_cnt = 4'h0;
          end
        end
        omcs_pkg::OMCS_RDATA: begin
          if (rise) begin
            next_cnt = cnt + 4'h1;
          end else if (fall && cnt == omcs_pkg::BITS_PER_BYTE) begin
            next_state = omcs_pkg::OMCS_RACK;
            next_drive_low = 1'b0;
            next_ptr = o_ptr + 8'h01;
          end else if (fall) begin
            next_sh = {sh[6:0], 1'b0};
            next_drive_low = ~sh[6];
          end
        end
        omcs_pkg::OMCS_RACK: begin
          if (rise) begin
            next_ack_ok = ~sda;
          end else if (fall && ack_ok) begin
            next_state = omcs_pkg::OMCS_RDATA;
            next_sh = i_rd_data;
            next_drive_low = ~i_rd_data[7];
            next_cnt = 4'h0;
          end else if (fall) begin
            next_state = omcs_pkg::OMCS_IDLE;
          end
        end
        default: begin
          next_state = omcs_pkg::OMCS_IDLE;
          next_drive_low = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state <= omcs_pkg::OMCS_IDLE;
      cnt <= 4'h0;
      sh <= 8'h00;
      o_ptr <= 8'h00;
      is_rd <= 1'b0;
      o_dev_diag <= 1'b0;
      first <= 1'b0;
      ack_ok <= 1'b0;
      wrote <= 1'b0;
      o_drive_low <= 1'b0;
      o_wr_en <= 1'b0;
      o_wr_addr <= 8'h00;
      o_wr_data <= 8'h00;
      o_stop_write <= 1'b0;
      o_wr_bytes <= 4'h0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      sh <= next_sh;
      o_ptr <= next_ptr;
      is_rd <= next_is_rd;
      o_dev_diag <= next_dev_diag;
      first <= next_first;
      ack_ok <= next_ack_ok;
      wrote <= next_wrote;
      o_drive_low <= next_drive_low;
      o_wr_en <= next_wr_en;
      o_wr_addr <= next_wr_addr;
      o_wr_data <= next_wr_data;
      o_stop_write <= next_stop_write;
      o_wr_bytes <= next_wr_bytes;
    end
  end
endmodule

//--- hw/omcs_top.sv
// Transmitter, receiver and management control of the optical module
`timescale 1ns/1ps
module omcs_top #(
  parameter int ON_CYC = omcs_pkg::T_ON_CYC,
  parameter int INIT_CYC = omcs_pkg::T_INIT_CYC,
  parameter int SERIAL_CYC = omcs_pkg::T_SERIAL_CYC,
  parameter int DATA_CYC = omcs_pkg::T_DATA_CYC,
  parameter int WR_SHORT_CYC = omcs_pkg::T_WR_SHORT_CYC,
  parameter int WR_LONG_CYC = omcs_pkg::T_WR_LONG_CYC
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_tx_disable,
  input wire logic i_fault_detect,
  input wire logic i_signal_detect,
  input wire logic i_monitor_ok,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_laser_on,
  output logic o_tx_fault,
  output logic o_rx_los,
  output logic o_sda,
  output logic o_sda_oe_n
);
  localparam int UP_MAX = (DATA_CYC > SERIAL_CYC) ? DATA_CYC : SERIAL_CYC;
  localparam int INIT_MAX = (INIT_CYC > ON_CYC) ? INIT_CYC : ON_CYC;
  localparam int UW = $clog2(UP_MAX + 1);
  localparam int IW = $clog2(INIT_MAX + 1);
  localparam int WW = $clog2(WR_LONG_CYC + 1);

  // Pins from outside the clock domain, first stage read by second only
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic dis_pin, fault_in, signal_in, monitor_in;
  logic dis_prev;
  logic dis_fall;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
      dis_prev <= 1'b0;
    end else begin
      sync_a <= {i_tx_disable, i_fault_detect, i_signal_detect, i_monitor_ok};
      sync_b <= sync_a;
      dis_prev <= dis_pin;
    end
  end

  assign dis_pin = sync_b[3];
  assign fault_in = sync_b[2];
  assign signal_in = sync_b[1];
  assign monitor_in = sync_b[0];
  assign dis_fall = dis_prev & ~dis_pin;

  // Timers: time since power-on, initialisation, internal write cycle
  logic [UW-1:0] up_cnt, next_up_cnt;
  logic [IW-1:0] init_cnt, next_init_cnt;
  logic [WW-1:0] wc_cnt, next_wc_cnt;
  logic serial_time, data_time, init_busy;
  logic wr_stop;
  logic [3:0] wr_bytes;

  assign serial_time = up_cnt >= UW'(SERIAL_CYC);
  assign data_time = up_cnt >= UW'(DATA_CYC);
  assign init_busy = init_cnt != '0;

  always_comb begin
    next_up_cnt = up_cnt;
    if (up_cnt != UW'(UP_MAX)) begin
      next_up_cnt = up_cnt + UW'(1);
    end
    next_init_cnt = init_cnt;
    if (dis_fall) begin
      next_init_cnt = IW'(ON_CYC);
    end else if (init_busy) begin
      next_init_cnt = init_cnt - IW'(1);
    end
    next_wc_cnt = wc_cnt;
    if (wr_stop && wr_bytes > omcs_pkg::WR_SHORT_MAX) begin
      next_wc_cnt = WW'(WR_LONG_CYC);
    end else if (wr_stop) begin
      next_wc_cnt = WW'(WR_SHORT_CYC);
    end else if (wc_cnt != '0) begin
      next_wc_cnt = wc_cnt - WW'(1);
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      up_cnt <= '0;
      init_cnt <= IW'(INIT_CYC);
      wc_cnt <= '0;
    end else begin
      up_cnt <= next_up_cnt;
      init_cnt <= next_init_cnt;
      wc_cnt <= next_wc_cnt;
    end
  end

  // Management slave and the byte it reaches
  logic drive_low, dev_diag, wr_en;
  logic [7:0] ptr, wr_addr, wr_data, status, rd_data;
  logic twi_ready, next_twi_ready;
  logic soft_dis, next_soft_dis;
  logic pend_val, next_pend_val;
  logic pend_vld, next_pend_vld;
  logic fault_latch, next_fault_latch;
  logic data_ready, next_data_ready;
  logic next_laser_on, next_tx_fault, next_rx_los;

  omcs_twi_slave u_twi (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .i_ready(twi_ready),
    .i_rd_data(rd_data),
    .o_drive_low(drive_low),
    .o_dev_diag(dev_diag),
    .o_ptr(ptr),
    .o_wr_en(wr_en),
    .o_wr_addr(wr_addr),
    .o_wr_data(wr_data),
    .o_stop_write(wr_stop),
    .o_wr_bytes(wr_bytes)
  );

  always_comb begin
    status = 8'h00;
    status[omcs_pkg::BIT_PIN_DISABLE] = dis_pin;
    status[omcs_pkg::BIT_SOFT_DISABLE] = soft_dis;
    status[omcs_pkg::BIT_TX_FAULT] = fault_latch;
    status[omcs_pkg::BIT_RX_LOS] = o_rx_los;
    status[omcs_pkg::BIT_DATA_READY] = data_ready;
    rd_data = omcs_pkg::READ_FILL;
    if (dev_diag && ptr == omcs_pkg::SOFT_CONTROL_AND_STATUS) begin
      rd_data = status;
    end
  end

  always_comb begin
    // Busy write cycle refuses the address so the host can poll
    next_twi_ready = serial_time && wc_cnt == '0 && !wr_stop;
    next_data_ready = data_time & monitor_in;
    next_pend_val = pend_val;
    next_pend_vld = pend_vld;
    next_soft_dis = soft_dis;
    if (wr_en && dev_diag && wr_addr == omcs_pkg::SOFT_CONTROL_AND_STATUS) begin
      next_pend_val = wr_data[omcs_pkg::BIT_SOFT_DISABLE];
      next_pend_vld = 1'b1;
    end
    // Soft bit acts only once the write is closed by its stop
    if (wr_stop && pend_vld) begin
      next_soft_dis = pend_val;
      next_pend_vld = 1'b0;
    end
    // A fault seen while the reset edge arrives stays latched
    next_fault_latch = fault_latch;
    if (dis_fall) begin
      next_fault_latch = 1'b0;
    end
    if (fault_in) begin
      next_fault_latch = 1'b1;
    end
    // Laser gated at once by either disable, so off time is a few cycles
    // Falling edge itself also blocks, as the restart timer loads one cycle late
    next_laser_on = !dis_pin && !dis_fall && !soft_dis && !fault_latch &&
      !init_busy;
    next_tx_fault = next_fault_latch;
    next_rx_los = ~signal_in;
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      twi_ready <= 1'b0;
      data_ready <= 1'b0;
      pend_val <= 1'b0;
      pend_vld <= 1'b0;
      soft_dis <= omcs_pkg::SOFT_DISABLE_RESET;
      fault_latch <= 1'b0;
      o_laser_on <= 1'b0;
      o_tx_fault <= 1'b0;
      o_rx_los <= 1'b1;
      o_sda <= 1'b0;
      o_sda_oe_n <= 1'b1;
    end else begin
      twi_ready <= next_twi_ready;
      data_ready <= next_data_ready;
      pend_val <= next_pend_val;
      pend_vld <= next_pend_vld;
      soft_dis <= next_soft_dis;
      fault_latch <= next_fault_latch;
      o_laser_on <= next_laser_on;
      o_tx_fault <= next_tx_fault;
      o_rx_los <= next_rx_los;
      o_sda <= 1'b0;
      o_sda_oe_n <= ~drive_low;
    end
  end
endmodule

//--- tb/omcs_top_assertions.sv
// Port assertions for the optical module control block
`timescale 1ns/1ps
module omcs_top_assertions #(
  parameter int SERIAL_CYC = 100
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_tx_disable,
  input wire logic i_fault_detect,
  input wire logic i_signal_detect,
  input wire logic i_monitor_ok,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_laser_on,
  input wire logic o_tx_fault,
  input wire logic o_rx_los,
  input wire logic o_sda,
  input wire logic o_sda_oe_n
);
  int up_cnt;
  int next_up_cnt;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // Saturates so it never wraps in long runs
  always_comb begin
    next_up_cnt = up_cnt;
    if (i_rst) begin
      next_up_cnt = 0;
    end else if (up_cnt < SERIAL_CYC) begin
      next_up_cnt = up_cnt + 1;
    end
  end
  always_ff @(posedge i_clock) begin
    up_cnt <= next_up_cnt;
  end
  a_pin_off: assert property ($rose(i_tx_disable) |-> ##[1:5] !o_laser_on)
    else $error("laser on after disable");
  a_restart_off: assert property ($fell(i_tx_disable) |-> !o_laser_on [*8])
    else $error("laser on during restart");
  a_init_off: assert property ($fell(i_rst) |-> !o_laser_on [*8])
    else $error("laser on during init");
  a_fault_set: assert property (i_fault_detect [*6] |-> o_tx_fault)
    else $error("fault output late");
  a_los_set: assert property (!i_signal_detect [*6] |-> o_rx_los)
    else $error("loss output late");
  a_los_clear: assert property (i_signal_detect [*6] |-> !o_rx_los)
    else $error("loss output stuck");
  a_ack_gate: assert property (!o_sda_oe_n |-> up_cnt >= SERIAL_CYC - 1)
    else $error("serial drive before ready");
  a_drive_scl_low: assert property ($fell(o_sda_oe_n) |-> !i_scl && !o_sda)
    else $error("data drive while clock high");
  c_ack: cover property ($fell(o_sda_oe_n));
  c_fault: cover property ($rose(o_tx_fault));
  c_los: cover property ($rose(o_rx_los) && i_monitor_ok);
endmodule
bind omcs_top omcs_top_assertions #(.SERIAL_CYC(SERIAL_CYC)) u_chk (
  .i_clock(i_clock), .i_rst(i_rst), .i_tx_disable(i_tx_disable),
  .i_fault_detect(i_fault_detect), .i_signal_detect(i_signal_detect),
  .i_monitor_ok(i_monitor_ok), .i_scl(i_scl), .i_sda(i_sda),
  .o_laser_on(o_laser_on), .o_tx_fault(o_tx_fault), .o_rx_los(o_rx_los),
  .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n));

//--- tb/omcs_host_model.sv
// Host controller model driving the two-wire management bus
`timescale 1ns/1ps
module omcs_host_model (
  input wire logic i_clock,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  // Both lines released, clock stands high between frames
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  // 16 cycles a bit: 160 ns clock, data moves only in the low phase
  task automatic bit_xfer(input logic b, output logic r);
    o_sda = b;
    wait_cyc(4);
    o_scl = 1'b1;
    wait_cyc(8);
    r = i_sda;
    o_scl = 1'b0;
    wait_cyc(4);
  endtask
  // Also serves as repeated start
  task automatic start();
    o_sda = 1'b1;
    wait_cyc(4);
    o_scl = 1'b1;
    wait_cyc(8);
    o_sda = 1'b0;
    wait_cyc(8);
    o_scl = 1'b0;
    wait_cyc(4);
  endtask
  task automatic stop();
    o_sda = 1'b0;
    wait_cyc(4);
    o_scl = 1'b1;
    wait_cyc(8);
    o_sda = 1'b1;
    wait_cyc(2000);
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], r);
    end
    bit_xfer(1'b1, r);
    ack = !r;
  endtask
  // Always ends with a NACK, so only single-byte reads
  task automatic get_byte(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, r);
      d[i] = r;
    end
    bit_xfer(1'b1, r);
  endtask
endmodule

//--- tb/omcs_top_tb.sv
// Self-checking bench for the optical module control block
`timescale 1ns/1ps
module omcs_top_tb;
  localparam int ON_CYC = 20;
  localparam int WR_S = 3000;
  logic clock;
  logic rst;
  logic tx_dis;
  logic fault;
  logic sig_ok;
  logic mon_ok;
  logic scl;
  logic host_sda;
  logic laser;
  logic tx_fault;
  logic rx_los;
  logic dev_sda;
  logic dev_oe_n;
  wire logic sda_line;
  wire logic [7:0] pins;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  // Pull-up: low wins from either side
  assign sda_line = host_sda & (dev_oe_n | dev_sda);
  assign pins = {5'h00, laser, tx_fault, rx_los};
  // Write cycle longer than bus-free gap, so busy polling is observable
  omcs_top #(.ON_CYC(ON_CYC), .INIT_CYC(50), .SERIAL_CYC(1000), .DATA_CYC(4000),
    .WR_SHORT_CYC(WR_S), .WR_LONG_CYC(2 * WR_S)) uut (
    .i_clock(clock), .i_rst(rst), .i_tx_disable(tx_dis), .i_fault_detect(fault),
    .i_signal_detect(sig_ok), .i_monitor_ok(mon_ok), .i_scl(scl), .i_sda(sda_line),
    .o_laser_on(laser), .o_tx_fault(tx_fault), .o_rx_los(rx_los), .o_sda(dev_sda),
    .o_sda_oe_n(dev_oe_n));
  omcs_host_model host (.i_clock(clock), .i_sda(sda_line), .o_scl(scl), .o_sda(host_sda));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic probe(input logic exp);
    logic a;
    host.start();
    host.put_byte({omcs_pkg::DIAGNOSTIC_ADDRESS, 1'b0}, a);
    host.stop();
    chk("address ack", {7'h00, exp}, {7'h00, a});
  endtask
  task automatic wr(input logic [7:0] d, input int n);
    logic a;
    host.start();
    host.put_byte({omcs_pkg::DIAGNOSTIC_ADDRESS, 1'b0}, a);
    host.put_byte(omcs_pkg::SOFT_CONTROL_AND_STATUS, a);
    repeat (n) host.put_byte(d, a);
    host.stop();
  endtask
  task automatic rd(input logic [7:0] dev, input logic [7:0] exp);
    logic a;
    logic [7:0] d;
    host.start();
    host.put_byte(dev, a);
    chk("address ack", 8'h01, {7'h00, a});
    host.put_byte(omcs_pkg::SOFT_CONTROL_AND_STATUS, a);
    host.start();
    host.put_byte(dev | 8'h01, a);
    host.get_byte(d);
    host.stop();
    chk("status byte", exp, d);
  endtask
  initial begin
    rst = 1'b1;
    tx_dis = 1'b0;
    fault = 1'b0;
    sig_ok = 1'b1;
    mon_ok = 1'b1;
    step(8);
    rst = 1'b0;
    step(2);
    chk("pins", 8'h01, pins);
    probe(1'b0);
    chk("pins", 8'h04, pins);
    rd(8'hA2, 8'h00);
    rd(8'hA0, 8'h00);
    sig_ok = 1'b0;
    step(6);
    chk("pins", 8'h05, pins);
    rd(8'hA2, 8'h03);
    // Monitoring not yet working: ready bit must drop
    mon_ok = 1'b0;
    rd(8'hA2, 8'h02);
    mon_ok = 1'b1;
    sig_ok = 1'b1;
    step(6);
    chk("pins", 8'h04, pins);
    wr(8'h40, 1);
    chk("pins", 8'h00, pins);
    probe(1'b0);
    probe(1'b1);
    rd(8'hA2, 8'h41);
    wr(8'h00, 5);
    probe(1'b0);
    probe(1'b0);
    probe(1'b1);
    chk("pins", 8'h04, pins);
    // Only one pin disable in the run, so spacing is kept
    tx_dis = 1'b1;
    step(5);
    chk("pins", 8'h00, pins);
    fault = 1'b1;
    step(6);
    chk("pins", 8'h02, pins);
    fault = 1'b0;
    rd(8'hA2, 8'h85);
    tx_dis = 1'b0;
    step(6);
    chk("pins", 8'h00, pins);
    step(ON_CYC + 10);
    chk("pins", 8'h04, pins);
    report_and_stop();
  end
endmodule
